/* File: shared/fpds_pkg.sv */
// Constants, types and operand classes for the double special-case block.
// Assumes a 64-bit double held as a pair register, high word in bits 63:32.
// Notes on behaviour
// - A double whose high word is zero but for the sign, with a nonzero low word, is class A.
// - A double with zero exponent and nonzero upper 20 fraction bits is class B.
// - A double whose high word is 7ff00000 or fff00000 and whose low word is nonzero is class C.
// - With flush mode set, any denormal input of the four operations acts as zero at full rate.
// - With flush mode clear, a divide with a denormal never yields a spurious zero or infinity.
// - Divide of denormal by denormal, or of zero by denormal, raises the FPU error trap.
// - With flush clear, denormal times infinity, in either order, raises the FPU error trap.
// - A class C NaN paired with a denormal writes the default quiet NaN in all four operations.
// - When the FPU error trap is taken, the destination pair register is not written.
// - Round toward zero never exceeds the exact magnitude and stays within one last-place unit.
// - The round-toward-zero path carries no excess above the exact magnitude at all.
// - Zero divisor, denormal dividend, trap enabled: divide-by-zero trap and no write.
// - Zero divisor, denormal dividend, trap disabled: a signed infinity is written.
package fpds_pkg;

	localparam int          SIGN_BIT      = 63;
	localparam int          EXP_MSB       = 62;
	localparam int          EXP_LSB       = 52;
	localparam int          RTZ_GUARD_W   = 8;
	localparam logic [10:0] EXP_ONES      = 11'h7ff;
	localparam logic [30:0] QNAN_C_HI     = 31'h7ff00000;
	localparam logic [63:0] QNAN_DEFAULT  = 64'h7ff7ffff_ffffffff;
	localparam logic [62:0] INF_MAG       = 63'h7ff00000_00000000;
	localparam logic [63:0] DATA_RST      = 64'h0;

	// Operations handled by the block
	typedef enum logic [1:0] {
		OP_DIVIDE,
		OP_ADD,
		OP_SUBTRACT,
		OP_MULTIPLY
	} fpds_op_t;

	// Outcome chosen at issue
	typedef enum logic [2:0] {
		KIND_ARITH,
		KIND_QNAN,
		KIND_INF,
		KIND_TRAP_DZ,
		KIND_TRAP_FPU
	} fpds_kind_t;

	// Operand classes
	typedef struct packed {
		logic zero;
		logic inf;
		logic nan;
		logic den;
		logic den_a;
		logic den_b;
		logic qnan_c;
	} fpds_cls_t;

	// Decision carried to the next stage
	typedef struct packed {
		fpds_kind_t  kind;
		logic        wr_en;
		logic [63:0] data;
	} fpds_dec_t;

endpackage : fpds_pkg

/* File: test/fpds_special_tb.sv */
// Self-checking bench for the double special-case selector.
// Assumes fpds_pkg is compiled first; the bench drives inputs on the falling edge.
module fpds_special_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          GW      = 8;
	localparam logic [63:0] DEN_A_P = 64'h00000000_00000005;
	localparam logic [63:0] DEN_A_N = 64'h80000000_00000001;
	localparam logic [63:0] DEN_B   = 64'h00012345_00000000;
	localparam logic [63:0] POS_INF = 64'h7ff00000_00000000;
	localparam logic [63:0] QNAN_C  = 64'h7ff00000_00000001;
	localparam logic [63:0] QNAN_CN = 64'hfff00000_80000000;
	localparam logic [63:0] NEG_INF  = {1'b1, fpds_pkg::INF_MAG};
	localparam logic [63:0] QNAN_DEF = fpds_pkg::QNAN_DEFAULT;

	// Short names for operations and outcomes
	localparam fpds_pkg::fpds_op_t   O_DIV   = fpds_pkg::OP_DIVIDE;
	localparam fpds_pkg::fpds_op_t   O_ADD   = fpds_pkg::OP_ADD;
	localparam fpds_pkg::fpds_op_t   O_MUL   = fpds_pkg::OP_MULTIPLY;
	localparam fpds_pkg::fpds_kind_t K_ARITH = fpds_pkg::KIND_ARITH;
	localparam fpds_pkg::fpds_kind_t K_QNAN  = fpds_pkg::KIND_QNAN;
	localparam fpds_pkg::fpds_kind_t K_INF   = fpds_pkg::KIND_INF;
	localparam fpds_pkg::fpds_kind_t K_DZ    = fpds_pkg::KIND_TRAP_DZ;
	localparam fpds_pkg::fpds_kind_t K_FPU   = fpds_pkg::KIND_TRAP_FPU;

	logic                 clk_sys, srst, issue_valid, denormal_flush_mode, dz_enable, rtz_valid;
	fpds_pkg::fpds_op_t   issue_op;
	logic [63:0]          source_pair_register, dest_pair_register;
	logic [63+GW:0]       rtz_exact;
	logic                 dec_valid_q, dec_wr_en_q, divide_by_zero_signal_q, fpu_error_q;
	fpds_pkg::fpds_kind_t dec_kind_q;
	logic [63:0]          dec_data_q, op_src_q, op_dst_q, rtz_result_q;
	logic                 rtz_valid_q;
	int                   fail_count;
	int                   checked;

	fpds_special #(.GW(GW)) dut_u (
		.clk_sys(clk_sys), .srst(srst), .issue_valid(issue_valid), .issue_op(issue_op),
		.source_pair_register(source_pair_register), .dest_pair_register(dest_pair_register),
		.denormal_flush_mode(denormal_flush_mode), .dz_enable(dz_enable),
		.rtz_valid(rtz_valid), .rtz_exact(rtz_exact), .dec_valid_q(dec_valid_q),
		.dec_kind_q(dec_kind_q), .dec_wr_en_q(dec_wr_en_q), .dec_data_q(dec_data_q),
		.divide_by_zero_signal_q(divide_by_zero_signal_q), .fpu_error_q(fpu_error_q),
		.op_src_q(op_src_q), .op_dst_q(op_dst_q), .rtz_valid_q(rtz_valid_q),
		.rtz_result_q(rtz_result_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and shared checking
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
			fail_count++;
		end
	endtask : check_val

	// Issue one op; the decision is judged at the next falling edge
	task automatic run_op(input fpds_pkg::fpds_op_t op, input logic [63:0] m, input logic [63:0] n,
			input logic fl, input logic dz, input fpds_pkg::fpds_kind_t kind,
			input logic [63:0] data);
		logic exp_wr;
		logic exp_dz;
		logic exp_fe;
		exp_wr = (kind == K_QNAN) || (kind == K_INF);
		exp_dz = (kind == K_DZ);
		exp_fe = (kind == K_FPU);
		issue_valid = 1'b1;
		issue_op = op;
		source_pair_register = m;
		dest_pair_register = n;
		denormal_flush_mode = fl;
		dz_enable = dz;
		@(negedge clk_sys);
		check_val({63'h0, dec_valid_q}, 64'h1, "valid");
		check_val({61'h0, dec_kind_q}, {61'h0, kind}, "kind");
		check_val({63'h0, dec_wr_en_q}, {63'h0, exp_wr}, "write");
		check_val(dec_data_q, data, "data");
		check_val({63'h0, divide_by_zero_signal_q}, {63'h0, exp_dz}, "dz");
		check_val({63'h0, fpu_error_q}, {63'h0, exp_fe}, "fpu error");
	endtask : run_op

	// Drop the issue and see the decision clear
	task automatic go_idle();
		issue_valid = 1'b0;
		@(negedge clk_sys);
		check_val({60'h0, dec_valid_q, dec_wr_en_q, divide_by_zero_signal_q, fpu_error_q},
			64'h0, "idle flags");
		check_val({61'h0, dec_kind_q}, {61'h0, K_ARITH}, "idle kind");
	endtask : go_idle

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_zero_divisor();
		run_op(O_DIV, 64'h0, DEN_A_N, 1'b0, 1'b1, K_DZ, 64'h0);
		run_op(O_DIV, 64'h0, DEN_A_N, 1'b0, 1'b0, K_INF, NEG_INF);
		run_op(O_DIV, 64'h80000000_00000000, DEN_A_N, 1'b0, 1'b0, K_INF, {1'b0, fpds_pkg::INF_MAG});
		run_op(O_DIV, 64'h80000000_00000000, DEN_B, 1'b0, 1'b0, K_INF, NEG_INF);
		go_idle();
	endtask : t_zero_divisor

	task automatic t_fpu_error();
		run_op(O_DIV, DEN_A_P, DEN_A_N, 1'b0, 1'b1, K_FPU, 64'h0);
		run_op(O_DIV, DEN_A_N, 64'h0, 1'b0, 1'b0, K_FPU, 64'h0);
		run_op(O_DIV, DEN_A_P, POS_INF, 1'b0, 1'b0, K_FPU, 64'h0);
		run_op(O_DIV, DEN_A_P, 64'h3ff00000_00000000, 1'b0, 1'b0, K_ARITH, 64'h0);
		run_op(O_MUL, DEN_A_N, POS_INF, 1'b0, 1'b0, K_FPU, 64'h0);
		run_op(O_MUL, POS_INF, DEN_A_P, 1'b0, 1'b0, K_FPU, 64'h0);
		run_op(O_ADD, 64'h7ff80000_00000000, DEN_B, 1'b0, 1'b0, K_FPU, 64'h0);
		run_op(O_ADD, 64'h3ff00000_00000000, DEN_B, 1'b0, 1'b0, K_ARITH, 64'h0);
		run_op(O_ADD, POS_INF, DEN_B, 1'b0, 1'b0, K_ARITH, 64'h0);
		go_idle();
	endtask : t_fpu_error

	task automatic t_qnan();
		for (int i = 0; i < 4; i++) begin
			run_op(fpds_pkg::fpds_op_t'(i), QNAN_C, DEN_B, 1'b0, 1'b1, K_QNAN, QNAN_DEF);
			run_op(fpds_pkg::fpds_op_t'(i), DEN_A_N, QNAN_CN, 1'b0, 1'b0, K_QNAN, QNAN_DEF);
		end
		go_idle();
	endtask : t_qnan

	task automatic t_flush();
		run_op(fpds_pkg::OP_DIVIDE, 64'h0, DEN_A_N, 1'b1, 1'b1, fpds_pkg::KIND_ARITH, 64'h0);
		check_val(op_dst_q, 64'h80000000_00000000, "flushed dividend");
		run_op(fpds_pkg::OP_MULTIPLY, DEN_B, POS_INF, 1'b1, 1'b0, fpds_pkg::KIND_ARITH, 64'h0);
		check_val(op_src_q, 64'h0, "flushed source");
		check_val(op_dst_q, POS_INF, "kept infinity");
		go_idle();
		check_val(op_dst_q, POS_INF, "operand hold");
	endtask : t_flush

	task automatic t_rtz();
		rtz_valid = 1'b1;
		rtz_exact = {1'b1, 63'h3ff00000_00001234, 8'hff};
		@(negedge clk_sys);
		check_val(rtz_result_q, 64'hbff00000_00001234, "rtz guard ones");
		rtz_exact = {1'b0, 63'h40000000_00000000, 8'h00};
		@(negedge clk_sys);
		check_val({63'h0, rtz_valid_q}, 64'h1, "rtz valid");
		check_val(rtz_result_q, 64'h40000000_00000000, "rtz exact");
		rtz_valid = 1'b0;
		@(negedge clk_sys);
		check_val({63'h0, rtz_valid_q}, 64'h0, "rtz idle");
		check_val(rtz_result_q, 64'h40000000_00000000, "rtz hold");
	endtask : t_rtz

	task automatic t_mid_reset();
		issue_valid = 1'b1;
		issue_op = O_MUL;
		source_pair_register = DEN_B;
		dest_pair_register = NEG_INF;
		denormal_flush_mode = 1'b0;
		srst = 1'b1;
		@(negedge clk_sys);
		srst = 1'b0;
		check_val({59'h0, dec_valid_q, dec_wr_en_q, fpu_error_q, rtz_valid_q,
			divide_by_zero_signal_q}, 64'h0, "reset flags");
		check_val({61'h0, dec_kind_q}, {61'h0, K_ARITH}, "reset kind");
		check_val(op_src_q | op_dst_q | dec_data_q | rtz_result_q, 64'h0, "reset data");
		// The held issue is taken at the first edge after release
		@(negedge clk_sys);
		check_val({62'h0, dec_valid_q, fpu_error_q}, 64'h3, "trap after reset");
		check_val({63'h0, dec_wr_en_q}, 64'h0, "no write after reset");
		go_idle();
	endtask : t_mid_reset

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, watchdog and main sequence
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	initial begin
		#50000;
		fail_count++;
		complete_run();
	end

	initial begin
		fail_count = 0;
		checked = 0;
		srst = 1'b1;
		issue_valid = 1'b0;
		issue_op = fpds_pkg::OP_DIVIDE;
		source_pair_register = 64'h0;
		dest_pair_register = 64'h0;
		denormal_flush_mode = 1'b0;
		dz_enable = 1'b0;
		rtz_valid = 1'b0;
		rtz_exact = '0;
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		t_zero_divisor();
		t_fpu_error();
		t_qnan();
		t_flush();
		t_rtz();
		t_zero_divisor();
		t_mid_reset();
		complete_run();
	end

endmodule : fpds_special_tb

/* File: verilog/fpds_classify.sv */
// Operand classifier for one double pair register.
// Purely combinational; the caller registers anything it drives out.
module fpds_classify (
	input  wire logic [63:0]      operand,
	output fpds_pkg::fpds_cls_t   cls
);

	logic [31:0] hi;
	logic [31:0] lo;
	logic [10:0] expo;
	logic        frac_nz;

	assign hi      = operand[63:32];
	assign lo      = operand[31:0];
	assign expo    = operand[fpds_pkg::EXP_MSB:fpds_pkg::EXP_LSB];
	assign frac_nz = (operand[51:0] != 52'h0);

	assign cls.den_a  = (hi[30:0] == 31'h0) && (lo != 32'h0);
	assign cls.den_b  = (hi[30:20] == 11'h0) && (hi[19:0] != 20'h0);
	assign cls.qnan_c = (hi[30:0] == fpds_pkg::QNAN_C_HI) && (lo != 32'h0);

	// General classes; a denormal is either class A or class B
	assign cls.den  = cls.den_a || cls.den_b;
	assign cls.zero = (expo == 11'h0) && !frac_nz;
	assign cls.inf  = (expo == fpds_pkg::EXP_ONES) && !frac_nz;
	assign cls.nan  = (expo == fpds_pkg::EXP_ONES) && frac_nz;

endmodule : fpds_classify

/* File: verilog/fpds_special.sv */
// Special-case selection for double divide, add, subtract and multiply.
// Assumes the arithmetic unit takes the flushed operands one cycle after issue
// and writes the destination itself when the decision is KIND_ARITH.
module fpds_special #(
	parameter int GW = fpds_pkg::RTZ_GUARD_W
) (
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 issue_valid,
	input  wire fpds_pkg::fpds_op_t   issue_op,
	input  wire logic [63:0]          source_pair_register,
	input  wire logic [63:0]          dest_pair_register,
	input  wire logic                 denormal_flush_mode,
	input  wire logic                 dz_enable,
	input  wire logic                 rtz_valid,
	input  wire logic [63+GW:0]       rtz_exact,
	output logic                      dec_valid_q,
	output fpds_pkg::fpds_kind_t      dec_kind_q,
	output logic                      dec_wr_en_q,
	output logic [63:0]               dec_data_q,
	output logic                      divide_by_zero_signal_q,
	output logic                      fpu_error_q,
	output logic [63:0]               op_src_q,
	output logic [63:0]               op_dst_q,
	output logic                      rtz_valid_q,
	output logic [63:0]               rtz_result_q
);

	////////////////////////////////////////////////////////////////////////////////
	// Classification

	logic [63:0]         opnd [2];
	fpds_pkg::fpds_cls_t cls  [2];
	fpds_pkg::fpds_cls_t cm;
	fpds_pkg::fpds_cls_t cn;
	logic [63:0]         flushed [2];

	assign opnd[0] = source_pair_register;
	assign opnd[1] = dest_pair_register;

	// both operands classified in the issue cycle
	for (genvar i = 0; i < 2; i++) begin : g_cls
		fpds_classify u_cls (
			.operand (opnd[i]),
			.cls     (cls[i])
		);
		// denormal replaced by signed zero under flush
		assign flushed[i] = (denormal_flush_mode && cls[i].den) ?
			{opnd[i][fpds_pkg::SIGN_BIT], 63'h0} : opnd[i];
	end

	assign cm = cls[0];
	assign cn = cls[1];

	////////////////////////////////////////////////////////////////////////////////
	// Decision

	fpds_pkg::fpds_dec_t dec_d;
	logic                any_den;
	logic                is_div;
	logic                is_mul;
	logic                res_sign;

	assign any_den  = cm.den || cn.den;
	assign is_div   = (issue_op == fpds_pkg::OP_DIVIDE);
	assign is_mul   = (issue_op == fpds_pkg::OP_MULTIPLY);
	assign res_sign = source_pair_register[fpds_pkg::SIGN_BIT] ^
		dest_pair_register[fpds_pkg::SIGN_BIT];

	// Priority selection of the special outcome
	always_comb begin
		dec_d.kind  = fpds_pkg::KIND_ARITH;
		dec_d.wr_en = 1'b0;
		dec_d.data  = fpds_pkg::DATA_RST;
		if (any_den && !denormal_flush_mode) begin
			if ((cm.qnan_c && cn.den) || (cn.qnan_c && cm.den)) begin
				dec_d.kind  = fpds_pkg::KIND_QNAN;
				dec_d.wr_en = 1'b1;
				dec_d.data  = fpds_pkg::QNAN_DEFAULT;
			end else if (is_div && cn.den && cm.zero) begin
				// trap or infinity on zero divisor
				if (dz_enable) begin
					dec_d.kind = fpds_pkg::KIND_TRAP_DZ;
				end else begin
					dec_d.kind  = fpds_pkg::KIND_INF;
					dec_d.wr_en = 1'b1;
					dec_d.data  = {res_sign, fpds_pkg::INF_MAG};
				end
			end else if (is_div && cm.den && (cn.den || cn.zero || cn.inf)) begin
				dec_d.kind = fpds_pkg::KIND_TRAP_FPU;
			end else if (is_mul && ((cm.den && cn.inf) || (cn.den && cm.inf))) begin
				dec_d.kind = fpds_pkg::KIND_TRAP_FPU;
			end else if (cm.nan || cn.nan) begin
				dec_d.kind = fpds_pkg::KIND_TRAP_FPU;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decision registers

	// Valid follows issue by one cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dec_valid_q <= 1'b0;
		end else begin
			dec_valid_q <= issue_valid;
		end
	end

	// traps never raise the write enable
	always_ff @(posedge clk_sys) begin
		if (srst || !issue_valid) begin
			dec_kind_q              <= fpds_pkg::KIND_ARITH;
			dec_wr_en_q             <= 1'b0;
			dec_data_q              <= fpds_pkg::DATA_RST;
			divide_by_zero_signal_q <= 1'b0;
			fpu_error_q             <= 1'b0;
		end else begin
			dec_kind_q              <= dec_d.kind;
			dec_wr_en_q             <= dec_d.wr_en;
			dec_data_q              <= dec_d.data;
			divide_by_zero_signal_q <= (dec_d.kind == fpds_pkg::KIND_TRAP_DZ);
			fpu_error_q             <= (dec_d.kind == fpds_pkg::KIND_TRAP_FPU);
		end
	end

	// flushed operands to the arithmetic unit
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			op_src_q <= fpds_pkg::DATA_RST;
			op_dst_q <= fpds_pkg::DATA_RST;
		end else if (issue_valid) begin
			op_src_q <= flushed[0];
			op_dst_q <= flushed[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Round toward zero

	// no excess above the exact magnitude
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rtz_valid_q  <= 1'b0;
			rtz_result_q <= fpds_pkg::DATA_RST;
		end else begin
			rtz_valid_q <= rtz_valid;
			if (rtz_valid) begin
				rtz_result_q <= {rtz_exact[63+GW], rtz_exact[62+GW:GW]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [62+GW:0] rtz_back;
	assign rtz_back = {rtz_result_q[62:0], {GW{1'b0}}};

	chk_qnan_write: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && ((cm.qnan_c && cn.den) || (cn.qnan_c && cm.den))
		|=> dec_wr_en_q && (dec_data_q == fpds_pkg::QNAN_DEFAULT) && !fpu_error_q)
		else $error("qnan with denormal did not write default qnan");

	chk_div_den_trap: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && is_div && cm.den && (cn.den || cn.zero)
		&& !cn.qnan_c |=> fpu_error_q && !dec_wr_en_q)
		else $error("denormal divisor did not trap");

	chk_mul_inf_trap: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && is_mul
		&& ((cm.den && cn.inf) || (cn.den && cm.inf)) |=> fpu_error_q && !dec_wr_en_q)
		else $error("denormal times infinity did not trap");

	chk_dz_trap: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && is_div && cn.den && cm.zero && dz_enable
		|=> divide_by_zero_signal_q && !dec_wr_en_q)
		else $error("zero divisor did not take divide by zero");

	chk_dz_inf: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && is_div && cn.den && cm.zero && !dz_enable
		|=> dec_wr_en_q && (dec_data_q == {$past(res_sign), fpds_pkg::INF_MAG}))
		else $error("zero divisor did not write signed infinity");

	chk_trap_nowrite: assert property (@(posedge clk_sys) disable iff (srst)
		(fpu_error_q || divide_by_zero_signal_q) |-> !dec_wr_en_q && dec_valid_q)
		else $error("trap with destination write");

	chk_flush_zero: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && denormal_flush_mode && cm.den
		|=> (op_src_q[62:0] == 63'h0) && !fpu_error_q && (dec_kind_q == fpds_pkg::KIND_ARITH))
		else $error("flush mode did not zero a denormal");

	chk_issue_latency: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid |=> dec_valid_q ##1 (dec_valid_q == $past(issue_valid)))
		else $error("decision not one cycle after issue");

	chk_rtz_bound: assert property (@(posedge clk_sys) disable iff (srst)
		rtz_valid |=> (rtz_back <= $past(rtz_exact[62+GW:0]))
		&& (($past(rtz_exact[62+GW:0]) - rtz_back) < (64'h1 << GW)))
		else $error("round toward zero out of bounds");

	chk_den_no_spurious: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && is_div && cm.den && (cn.den || cn.zero || cn.inf)
		|=> (dec_kind_q == fpds_pkg::KIND_TRAP_FPU) && !dec_wr_en_q)
		else $error("denormal divisor gave a zero or infinity");

	chk_nan_den_trap: assert property (@(posedge clk_sys) disable iff (srst)
		issue_valid && !denormal_flush_mode && any_den && (cm.nan || cn.nan)
		&& !cm.qnan_c && !cn.qnan_c |=> fpu_error_q && !dec_wr_en_q)
		else $error("denormal with other nan did not trap");

	cov_qnan: cover property (@(posedge clk_sys) dec_kind_q == fpds_pkg::KIND_QNAN);
	cov_dz:   cover property (@(posedge clk_sys) divide_by_zero_signal_q);
	cov_fpu:  cover property (@(posedge clk_sys) fpu_error_q);
	cov_inf:  cover property (@(posedge clk_sys) dec_kind_q == fpds_pkg::KIND_INF);

endmodule : fpds_special
